// >>> sefi_event_flags.sv
// Function
// - Flag bit 0 sets on port A sync activity or polarity change.
// - Flag bit 1 sets on port B sync activity or polarity change.
// - Flag bit 4 sets when selected channel sync changes.
// - Flag bit 5 sets when selected channel sync timing settles.
// - Flag bit 6 sets on every vertical sync of the selected channel.
// - Flag bit 7 sets when phase adjustment completes.
// - Writing one clears a flag bit; zero leaves it alone.
// - Mask bit zero enables, one suppresses, the matching interrupt.
// - Mask bit 0 gates port A change interrupt.
// - Mask bit 1 gates port B change interrupt.
// - Mask bit 4 gates selected channel disruption interrupt.
// - Mask bit 5 gates selected channel settled interrupt.
// - Mask bit 7 gates phase adjustment done interrupt.
// - Channel select code 0 picks port A, 1 picks port B.
// - Configuration bit 3 selects AC or DC coupling.
// - RGB: 300mV clamp, half shift, black target 0x00 everywhere.
// - YPbPr: 600mV clamp red/blue, 300mV green, shift green only.
// - YPbPr black target 0x00 green, 0x80 red and blue.
// - Horizontal sync active only if periodic above 1 kHz.
// - Vertical sync active only if periodic above 20 Hz.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module sefi_event_flags #(
  parameter int HS_MAX = sefi_pkg::HS_MAX_CYC,
  parameter int VS_MAX = sefi_pkg::VS_MAX_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // Host register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [7:0]        reg_rdata,
  // Sync inputs of both ports
  input  wire sefi_pkg::sefi_sync_s port_a_sync,
  input  wire sefi_pkg::sefi_sync_s port_b_sync,
  // Events from neighbouring blocks
  input  wire logic              sel_settled,
  input  wire logic              phase_adjust_done,
  // Front-end control
  output var  logic              irq_q,
  output var  logic [1:0]        chan_sel_q,
  output var  logic              coupling_select_q,
  output var  logic              clamp_source_sel_q,
  output var  logic              clamp_pol_q,
  output var  sefi_pkg::sefi_chan_s red_cfg_q,
  output var  sefi_pkg::sefi_chan_s green_cfg_q,
  output var  sefi_pkg::sefi_chan_s blue_cfg_q
);
  import sefi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Activity monitors: one per sync line, four lines in all.

  localparam int CW = $clog2(VS_MAX + 2);

  logic [3:0]    line_in;
  logic [3:0]    line_d1_q;
  logic [3:0]    act_q;
  logic [3:0]    pol_q;
  logic [CW-1:0] cnt_q [4];
  logic [CW-1:0] hi_q  [4];
  logic [CW-1:0] lo_q  [4];

  assign line_in = {port_b_sync.vsync, port_b_sync.hsync,
                    port_a_sync.vsync, port_a_sync.hsync};

  function automatic logic [CW-1:0] limit_of(input int idx);
    limit_of = (idx % 2 == 0) ? CW'(HS_MAX) : CW'(VS_MAX);
  endfunction : limit_of

  // A line is active only while each full period repeats the last low time, has a nonzero
  // high time and stays under the frequency limit; a missed edge drops activity.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_d1_q <= 4'h0;
      act_q     <= 4'h0;
      pol_q     <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= '0;
        hi_q[i]  <= '0;
        lo_q[i]  <= '0;
      end
    end else begin
      line_d1_q <= line_in;
      for (int i = 0; i < 4; i++) begin
        if (line_in[i] != line_d1_q[i]) begin
          cnt_q[i] <= '0;
          if (line_d1_q[i]) begin
            hi_q[i] <= cnt_q[i];
          end else begin
            lo_q[i] <= cnt_q[i];
            act_q[i] <= (hi_q[i] != '0) && (lo_q[i] == cnt_q[i])
                        && (CW'(hi_q[i] + cnt_q[i]) < limit_of(i));
            // Judged once per period, high time against low time, so a steady
            // line keeps one polarity instead of flipping on every edge.
            pol_q[i] <= (hi_q[i] > cnt_q[i]);
          end
        end else if (cnt_q[i] >= limit_of(i)) begin
          act_q[i] <= 1'b0;
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event detection.

  logic [3:0] act_d1_q;
  logic [3:0] pol_d1_q;
  logic [3:0] diff;
  logic [1:0] sel_diff;
  logic       vs_sel;
  logic       vs_sel_d1_q;
  logic       settled_d1_q;
  logic       phase_d1_q;
  logic [7:0] event_set;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_d1_q     <= 4'h0;
      pol_d1_q     <= 4'h0;
      vs_sel_d1_q  <= 1'b0;
      settled_d1_q <= 1'b0;
      phase_d1_q   <= 1'b0;
    end else begin
      act_d1_q     <= act_q;
      pol_d1_q     <= pol_q;
      vs_sel_d1_q  <= vs_sel;
      settled_d1_q <= sel_settled;
      phase_d1_q   <= phase_adjust_done;
    end
  end

  // Polarity only counts while the line is active, so noise does not flood flags.
  assign diff     = (act_q ^ act_d1_q) | ((pol_q ^ pol_d1_q) & act_q);
  assign sel_diff = (chan_sel_q == CH_INPUT_PORT_B) ? diff[3:2] : diff[1:0];
  assign vs_sel   = (chan_sel_q == CH_INPUT_PORT_B) ? port_b_sync.vsync
                                                    : port_a_sync.vsync;

  always_comb begin
    event_set               = 8'h00;
    event_set[FLG_PORT_A]   = |diff[1:0];
    event_set[FLG_PORT_B]   = |diff[3:2];
    event_set[FLG_DISRUPT]  = |sel_diff;
    event_set[FLG_SETTLED]  = sel_settled & ~settled_d1_q;
    event_set[FLG_VSYNC]    = vs_sel & ~vs_sel_d1_q;
    event_set[FLG_PHASE]    = phase_adjust_done & ~phase_d1_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic [7:0] setup_q;
  logic [7:0] clr;

  assign clr = (reg_wr && reg_addr == ADDR_EVENT_FLAGS) ? reg_wdata : 8'h00;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= RST_EVENT_FLAGS;
    end else begin
      flags_q <= ((flags_q & ~clr) | event_set) & FLAG_IMPL;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q  <= RST_EVENT_MASK;
      setup_q <= RST_INPUT_SETUP;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_EVENT_MASK) begin
        mask_q <= reg_wdata;
      end
      if (reg_addr == ADDR_INPUT_SETUP) begin
        setup_q <= reg_wdata & CFG_IMPL;
      end
    end
  end

  // Mask polarity is zero-enables for every bit.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & ~mask_q);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_EVENT_FLAGS: reg_rdata <= flags_q;
        ADDR_EVENT_MASK:  reg_rdata <= mask_q;
        ADDR_INPUT_SETUP: reg_rdata <= setup_q;
        ADDR_SYNC_MON:    reg_rdata <= {pol_q, act_q};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Front-end control decode; registered so every output comes from a flop.

  function automatic sefi_chan_s chan_cfg(input logic wide_clamp, input logic shift,
                                          input logic [7:0] black);
    chan_cfg.clamp_mv   = wide_clamp ? CLAMP_HIGH_MV : CLAMP_LOW_MV;
    chan_cfg.half_shift = shift;
    chan_cfg.black_code = black;
  endfunction : chan_cfg

  logic ypbpr;
  assign ypbpr = setup_q[CFG_COLOUR];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_sel_q         <= CH_INPUT_PORT_A;
      coupling_select_q  <= 1'b0;
      clamp_source_sel_q <= 1'b0;
      clamp_pol_q        <= 1'b0;
      red_cfg_q          <= '0;
      green_cfg_q        <= '0;
      blue_cfg_q         <= '0;
    end else begin
      chan_sel_q         <= setup_q[CFG_CHSEL_LSB +: 2];
      coupling_select_q  <= setup_q[CFG_COUPLING];
      clamp_source_sel_q <= setup_q[CFG_CLAMP_SRC];
      clamp_pol_q        <= setup_q[CFG_CLAMP_POL];
      red_cfg_q   <= chan_cfg(ypbpr, ~ypbpr, ypbpr ? BLACK_MID : BLACK_ZERO);
      green_cfg_q <= chan_cfg(1'b0, 1'b1, BLACK_ZERO);
      blue_cfg_q  <= chan_cfg(ypbpr, ~ypbpr, ypbpr ? BLACK_MID : BLACK_ZERO);
    end
  end
endmodule : sefi_event_flags
`default_nettype wire

// >>> sefi_pkg.sv
`default_nettype none
package sefi_pkg;
  // Register offsets (byte-wide registers on the host port).
  localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_EVENT_MASK   = 8'h05;
  localparam logic [7:0] ADDR_INPUT_SETUP  = 8'h10;
  localparam logic [7:0] ADDR_SYNC_MON     = 8'h20;

  // Reset values.
  localparam logic [7:0] RST_EVENT_FLAGS   = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK    = 8'hff;
  localparam logic [7:0] RST_INPUT_SETUP   = 8'h00;

  // Event flag bit positions.
  localparam int FLG_PORT_A   = 0;
  localparam int FLG_PORT_B   = 1;
  localparam int FLG_DISRUPT  = 4;
  localparam int FLG_SETTLED  = 5;
  localparam int FLG_VSYNC    = 6;
  localparam int FLG_PHASE    = 7;
  localparam logic [7:0] FLAG_IMPL = 8'hf3;

  // Input setup fields.
  localparam int CFG_CHSEL_LSB  = 0;
  localparam int CFG_COUPLING   = 3;
  localparam int CFG_COLOUR     = 4;
  localparam int CFG_CLAMP_SRC  = 6;
  localparam int CFG_CLAMP_POL  = 7;
  localparam logic [7:0] CFG_IMPL = 8'hdb;

  // Channel codes.
  localparam logic [1:0] CH_INPUT_PORT_A = 2'h0;
  localparam logic [1:0] CH_INPUT_PORT_B = 2'h1;

  // Clamp levels in millivolts and black-level target codes.
  localparam logic [9:0] CLAMP_LOW_MV  = 10'd300;
  localparam logic [9:0] CLAMP_HIGH_MV = 10'd600;
  localparam logic [7:0] BLACK_ZERO    = 8'h00;
  localparam logic [7:0] BLACK_MID     = 8'h80;

  // Activity thresholds: sync period must be below the inverse of the least frequency.
  localparam int  CLK_HZ        = 100_000_000;
  localparam int  HS_MIN_HZ     = 1_000;
  localparam int  VS_MIN_HZ     = 20;
  localparam int  HS_MAX_CYC    = CLK_HZ / HS_MIN_HZ;
  localparam int  VS_MAX_CYC    = CLK_HZ / VS_MIN_HZ;

  typedef struct packed {
    logic hsync;
    logic vsync;
  } sefi_sync_s;

  typedef struct packed {
    logic [9:0] clamp_mv;
    logic       half_shift;
    logic [7:0] black_code;
  } sefi_chan_s;
endpackage : sefi_pkg
`default_nettype wire

// >>> sefi_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sefi_properties #(
  parameter int HS_MAX = 40,
  parameter int VS_MAX = 400
) (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  // Host register port
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  // Front-end control
  input wire logic                 irq_q,
  input wire logic [1:0]           chan_sel_q,
  input wire logic                 coupling_select_q,
  input wire sefi_pkg::sefi_chan_s red_cfg_q,
  input wire sefi_pkg::sefi_chan_s green_cfg_q,
  input wire sefi_pkg::sefi_chan_s blue_cfg_q
);
  import sefi_pkg::*;
  localparam sefi_chan_s CFG_RGB = {CLAMP_LOW_MV, 1'b1, BLACK_ZERO};
  localparam sefi_chan_s CFG_YPB = {CLAMP_HIGH_MV, 1'b0, BLACK_MID};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // The decoded configs lag reset release by one edge, so they are judged only after it.
  logic live_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end
  sequence s_setup_wr;
    reg_wr && reg_addr == ADDR_INPUT_SETUP;
  endsequence
  sequence s_mask_wr;
    reg_wr && reg_addr == ADDR_EVENT_MASK;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_chan_select: assert property (s_setup_wr |=> ##1 chan_sel_q == $past(reg_wdata[1:0], 2))
    else $error("channel select does not follow setup write");
  a_coupling_copy: assert property (s_setup_wr |=> ##1 coupling_select_q == $past(reg_wdata[3], 2))
    else $error("coupling does not follow setup write");
  a_colour_cfg: assert property (s_setup_wr |=> ##1
      red_cfg_q == ($past(reg_wdata[4], 2) ? CFG_YPB : CFG_RGB))
    else $error("red config does not follow colour format");
  a_blue_match: assert property (live_q |-> blue_cfg_q == red_cfg_q)
    else $error("blue config differs from red");
  a_green_fixed: assert property (live_q |-> green_cfg_q == CFG_RGB)
    else $error("green config wrong");
  a_mask_read: assert property (s_mask_wr ##1 (reg_rd && reg_addr == ADDR_EVENT_MASK)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mask readback wrong");
  a_setup_read: assert property (s_setup_wr ##1 (reg_rd && reg_addr == ADDR_INPUT_SETUP)
      |=> reg_rdata == ($past(reg_wdata, 2) & CFG_IMPL))
    else $error("setup readback wrong");
  a_flag_pad: assert property (reg_rd && reg_addr == ADDR_EVENT_FLAGS |=> reg_rdata[3:2] == 2'b00)
    else $error("unused flag bits read nonzero");
  a_mask_quiet: assert property (s_mask_wr and reg_wdata == 8'hff |=> ##1 !irq_q)
    else $error("interrupt with every event masked");
endmodule : sefi_properties
`default_nettype wire

// >>> tb_sefi_event_flags.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sefi_event_flags;
  import sefi_pkg::*;
  localparam sefi_chan_s RGB = {CLAMP_LOW_MV, 1'b1, BLACK_ZERO};
  localparam sefi_chan_s YPB = {CLAMP_HIGH_MV, 1'b0, BLACK_MID};
  logic       sys_clk, reset_n, reg_wr, reg_rd, sel_settled, phase_adjust_done;
  logic       irq_q, coupling_select_q, clamp_source_sel_q, clamp_pol_q, en_a, en_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] chan_sel_q;
  logic [4:0] ph;
  sefi_sync_s port_a_sync, port_b_sync;
  sefi_chan_s red_cfg_q, green_cfg_q, blue_cfg_q;
  int         bad_count, samples_checked;
  sefi_event_flags #(.HS_MAX(40), .VS_MAX(400)) dut_u (.sys_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_a_sync, .port_b_sync, .sel_settled,
    .phase_adjust_done, .irq_q, .chan_sel_q, .coupling_select_q, .clamp_source_sel_q,
    .clamp_pol_q, .red_cfg_q, .green_cfg_q, .blue_cfg_q);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Period 20 cycles sits well inside the shortened limit of 40.
  always @(posedge sys_clk) begin
    ph <= (ph == 5'd9) ? 5'd0 : ph + 5'd1;
    if (ph == 5'd9 && en_a) port_a_sync.hsync <= !port_a_sync.hsync;
    if (ph == 5'd9 && en_b) port_b_sync.hsync <= !port_b_sync.hsync;
  end
  task automatic chk(string n, logic [18:0] g, logic [18:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Tasks start and end just after an edge so that accesses run back to back.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rc(string n, logic [7:0] a, logic [7:0] m, logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(n, reg_rdata & m, e);
  endtask : rc
  task automatic cyc(int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, reg_wr, reg_rd, sel_settled, phase_adjust_done, en_a, en_b} = '0;
    {reg_addr, reg_wdata, ph, bad_count, samples_checked} = '0;
    port_a_sync = '0;
    port_b_sync = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    rc("flags", ADDR_EVENT_FLAGS, 8'hff, RST_EVENT_FLAGS);
    rc("mask", ADDR_EVENT_MASK, 8'hff, RST_EVENT_MASK);
    rc("setup", ADDR_INPUT_SETUP, 8'hff, RST_INPUT_SETUP);
    rc("unmapped", 8'h07, 8'hff, 8'h00);
    wr(ADDR_INPUT_SETUP, 8'h11);
    rc("setup", ADDR_INPUT_SETUP, 8'hff, 8'h11);
    cyc(1);
    chk("chan", chan_sel_q, CH_INPUT_PORT_B);
    chk("red", red_cfg_q, YPB);
    chk("blue", blue_cfg_q, YPB);
    chk("green", green_cfg_q, RGB);
    wr(ADDR_INPUT_SETUP, 8'hff);
    rc("setup", ADDR_INPUT_SETUP, 8'hff, CFG_IMPL);
    chk("clamp_src", clamp_source_sel_q, 1'b1);
    chk("clamp_pol", clamp_pol_q, 1'b1);
    wr(ADDR_INPUT_SETUP, 8'h08);
    cyc(2);
    chk("coupling", coupling_select_q, 1'b1);
    chk("red", red_cfg_q, RGB);
    wr(ADDR_INPUT_SETUP, 8'h00);
    phase_adjust_done <= 1'b1;
    cyc(3);
    rc("flags", ADDR_EVENT_FLAGS, 8'h8c, 8'h80);
    wr(ADDR_EVENT_MASK, 8'h7f);
    cyc(3);
    chk("irq", irq_q, 1'b1);
    wr(ADDR_EVENT_MASK, 8'hff);
    cyc(3);
    chk("irq", irq_q, 1'b0);
    wr(ADDR_EVENT_FLAGS, 8'h7f);
    rc("flags", ADDR_EVENT_FLAGS, 8'h80, 8'h80);
    wr(ADDR_EVENT_FLAGS, 8'h80);
    phase_adjust_done <= 1'b0;
    rc("flags", ADDR_EVENT_FLAGS, 8'h80, 8'h00);
    // The new event lands on the very edge that takes the clear.
    phase_adjust_done <= 1'b1;
    wr(ADDR_EVENT_FLAGS, 8'hff);
    rc("flags", ADDR_EVENT_FLAGS, 8'h80, 8'h80);
    sel_settled <= 1'b1;
    cyc(3);
    rc("flags", ADDR_EVENT_FLAGS, 8'h20, 8'h20);
    wr(ADDR_EVENT_MASK, 8'hdf);
    rc("mask", ADDR_EVENT_MASK, 8'hff, 8'hdf);
    cyc(3);
    chk("irq", irq_q, 1'b1);
    wr(ADDR_EVENT_MASK, 8'hff);
    wr(ADDR_EVENT_FLAGS, 8'hff);
    port_a_sync.vsync <= 1'b1;
    cyc(3);
    rc("flags", ADDR_EVENT_FLAGS, 8'h40, 8'h40);
    wr(ADDR_EVENT_FLAGS, 8'hff);
    en_a <= 1'b1;
    cyc(120);
    rc("flags", ADDR_EVENT_FLAGS, 8'h13, 8'h11);
    wr(ADDR_EVENT_FLAGS, 8'hff);
    en_b <= 1'b1;
    cyc(120);
    rc("flags", ADDR_EVENT_FLAGS, 8'h13, 8'h02);
    wr(ADDR_EVENT_FLAGS, 8'hff);
    en_a <= 1'b0;
    cyc(120);
    rc("flags", ADDR_EVENT_FLAGS, 8'h13, 8'h11);
    wr(ADDR_EVENT_MASK, 8'hfe);
    cyc(3);
    chk("irq", irq_q, 1'b1);
    wr(ADDR_EVENT_MASK, 8'hef);
    cyc(3);
    chk("irq", irq_q, 1'b1);
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_sefi_event_flags
bind sefi_event_flags sefi_properties #(.HS_MAX(HS_MAX), .VS_MAX(VS_MAX)) sefi_chk_u (
  .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_q,
  .chan_sel_q, .coupling_select_q, .red_cfg_q, .green_cfg_q, .blue_cfg_q);
`default_nettype wire
